/* logic/reset_boot_pkg.sv */
// reset_boot_pkg: constants, bus carriers and encodings of the reset and boot block.
// assumes one 125 MHz mclk and an AXI4-Lite master reaching the top system page.
// Behaviour
// - floating erase pin reads as deasserted
// - two nonvolatile detector bits persist
// - set and clear commands change nv bit
// - nv bit 0 enables undervoltage detector
// - erase pin clears nv bit 0
// - nv bit 1 enables undervoltage reset
// - erase pin disables undervoltage reset
// - eight fixed calibration bits, erase-proof
// - test, ms0, ms1 high, ms2 low: fast programming
// - test and all mode lines high: recovery
// - fast mode accepts programming port commands
// - registers decode in top 4 KB
// - report cause of most recent reset
// - shape external reset pulse length
// - power-on reset reinitializes everything
// - detector acts after about 1 us of low supply, releases on recovery
// - ignore dips shorter than about 1 us
// - power-on and undervoltage inhibit flash
// - erase pin clears all lock bits
package reset_boot_pkg;
  localparam logic [19:0] SYS_PAGE = 20'hFFFFF;
  localparam logic [11:0] REG_RST_CTRL = 12'hD00;
  localparam logic [11:0] REG_RST_STATUS = 12'hD04;
  localparam logic [11:0] REG_RST_MODE = 12'hD08;
  localparam logic [11:0] REG_NV_CMD = 12'hF64;
  localparam logic [11:0] REG_NV_STATUS = 12'hF68;
  localparam logic [11:0] REG_LOCK = 12'hF6C;
  localparam logic [7:0] WR_KEY = 8'hA5;
  localparam int KEY_LSB = 24;
  localparam int ARG_LSB = 8;
  localparam int SWRST_BIT = 0;
  localparam int PLEN_LSB = 8;
  localparam int CAUSE_LSB = 8;
  localparam int UV_BIT = 16;
  localparam int LINE_BIT = 17;
  localparam int CALIB_LSB = 8;
  localparam int CMDERR_BIT = 16;
  localparam int FAST_BIT = 17;
  localparam int RECOVER_BIT = 18;
  localparam int ERASE_BIT = 19;
  localparam logic [7:0] CMD_SET_LOCK = 8'h02;
  localparam logic [7:0] CMD_CLR_LOCK = 8'h04;
  localparam logic [7:0] CMD_SET_NV = 8'h0B;
  localparam logic [7:0] CMD_CLR_NV = 8'h0D;
  localparam logic [3:0] PLEN_RESET = 4'h1;
  localparam logic [2:0] CAUSE_POWER = 3'h0;
  localparam logic [2:0] CAUSE_UV = 3'h1;
  localparam logic [2:0] CAUSE_WATCHDOG = 3'h2;
  localparam logic [2:0] CAUSE_SOFTWARE = 3'h3;
  localparam logic [2:0] CAUSE_USER = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam int NV_COUNT = 2;
  localparam int CALIB_W = 8;
  localparam int LOCK_COUNT = 16;
  localparam int PIN_COUNT = 7;
  localparam int PIN_ERASE = 0;
  localparam int PIN_TEST = 1;
  localparam int PIN_MS0 = 2;
  localparam int PIN_MS1 = 3;
  localparam int PIN_MS2 = 4;
  localparam int PIN_LINE = 5;
  localparam int PIN_UV = 6;
  localparam logic [6:0] PIN_RESET = 7'h20;
  localparam int CLK_PERIOD_NS = 8;
  localparam int DIP_NS = 1000;
  localparam int DIP_CYCLES = (DIP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_UNIT_NS = 1000;
  localparam int PULSE_UNIT_CYCLES = (PULSE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SYNC_SETTLE = 3'h4;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_PULSE, SEQ_WAIT} seq_type;

  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axi_rsp_type;
endpackage : reset_boot_pkg

/* logic/pin_sync.sv */
// pin_sync: three-stage synchroniser for one board pin with agreement check.
// assumes the pin is asynchronous to mclk; output follows once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // pin and settled level
  input wire logic pin,
  output logic level
);
  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } sync_type;

  sync_type st;
  sync_type next_st;

  always_comb begin
    next_st = st;
    next_st.stage = {st.stage[1:0], pin};
    if (st.stage[1] == st.stage[2]) begin
      next_st.level = st.stage[2];
    end
    if (sys_rst) begin
      next_st.stage = {3{RESET_LEVEL}};
      next_st.level = RESET_LEVEL;
    end
  end

  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  assign level = st.level;
endmodule : pin_sync
`default_nettype wire

/* logic/dip_filter.sv */
// dip_filter: qualifies the undervoltage comparator so that short dips are dropped.
// assumes raw is already synchronised to mclk and is high while the supply is low.
`timescale 1ns/10ps
`default_nettype none
module dip_filter import reset_boot_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // comparator in, qualified event out
  input wire logic enable,
  input wire logic raw,
  output logic detect
);
  localparam logic [7:0] DIP_LIMIT = 8'(DIP_CYCLES);

  typedef struct packed {
    logic [7:0] count;
    logic detect;
  } dip_type;

  dip_type st;
  dip_type next_st;

  always_comb begin
    next_st = st;
    if (sys_rst || !enable || !raw) begin
      next_st.count = 8'h00;
      next_st.detect = 1'b0;
    end else if (st.count != DIP_LIMIT) begin
      next_st.count = st.count + 8'h01;
    end else begin
      next_st.detect = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  assign detect = st.detect;

  a_dip_release: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (!raw || !enable) |=> !st.detect)
    else $error("detect held after supply recovered");
  a_dip_length: assert property (
    @(posedge mclk) disable iff (sys_rst)
    $rose(st.detect) |-> $past(st.count) == DIP_LIMIT && $past(raw))
    else $error("detect raised before dip length");
endmodule : dip_filter
`default_nettype wire

/* logic/nv_reset_boot_config.sv */
// nv_reset_boot_config: nonvolatile detector bits, locks, boot mode pins,
// reset cause and external reset shaping behind an AXI4-Lite slave.
// assumes sys_rst is the power-on reset and the flash array reloads nv bits.
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module nv_reset_boot_config import reset_boot_pkg::*; (
  // clock and power-on reset
  input wire logic mclk,
  input wire logic sys_rst,
  // register bus
  input wire axi_req_type axi_req,
  output axi_rsp_type axi_rsp,
  // board pins
  input wire logic erase_pin,
  input wire logic test_mode_pin,
  input wire logic mode_select_line_0,
  input wire logic mode_select_line_1,
  input wire logic mode_select_line_2,
  input wire logic external_reset_line_in,
  output logic external_reset_line_out,
  output logic external_reset_line_oe,
  // analog and nonvolatile store
  input wire logic undervoltage_detector_raw,
  input wire logic [NV_COUNT-1:0] nv_stored,
  input wire logic [CALIB_W-1:0] calib_stored,
  output logic undervoltage_detector_enable,
  output logic [NV_COUNT-1:0] nv_image,
  output logic [CALIB_W-1:0] calib_bits,
  output logic [LOCK_COUNT-1:0] lock_bits,
  output logic flash_inhibit,
  // reset sources and results
  input wire logic watchdog_reset,
  output logic core_reset,
  // fast programming port
  output logic fast_programming_port_enable,
  output logic boot_recovery,
  input wire logic fpp_cmd_valid,
  input wire logic [15:0] fpp_cmd_word,
  output logic fpp_cmd_ready
);
  localparam logic [10:0] PULSE_UNIT = 11'(PULSE_UNIT_CYCLES);

  typedef struct packed {
    logic aw_held;
    logic [31:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [NV_COUNT-1:0] nv;
    logic [CALIB_W-1:0] calib;
    logic [LOCK_COUNT-1:0] lock;
    logic cmd_err;
    logic [2:0] cause;
    logic [3:0] plen;
    seq_type seq;
    logic [10:0] count;
    logic swrst;
    logic [2:0] settle;
    logic sampled;
    logic fast;
    logic recover;
    logic inhibit;
    logic oe;
    logic core_rst;
  } core_type;

  core_type st, next_st;
  logic [PIN_COUNT-1:0] pins_raw, lv;
  logic erase_level, line_level, uv_detect, uv_req;
  logic bus_wr, bus_cmd, cmd_go;
  logic [7:0] cmd_v, arg_v;
  logic [10:0] target;

  // a floating erase pin has a pull-down, so it resets and reads as low
  assign pins_raw = {undervoltage_detector_raw, external_reset_line_in,
                     mode_select_line_2, mode_select_line_1,
                     mode_select_line_0, test_mode_pin, erase_pin};

  generate
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_sync
      pin_sync #(
        .RESET_LEVEL(PIN_RESET[i])
      ) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .pin(pins_raw[i]),
        .level(lv[i])
      );
    end
  endgenerate

  assign erase_level = lv[PIN_ERASE];
  assign line_level = lv[PIN_LINE];

  dip_filter u_dip (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .enable(st.nv[0]),
    .raw(lv[PIN_UV]),
    .detect(uv_detect)
  );

  // undervoltage resets only with both nv bits set
  assign uv_req = st.nv[0] && st.nv[1] && uv_detect;
  assign target = 11'(({7'h00, st.plen} + 11'h001) * PULSE_UNIT);

  function automatic logic [1:0] decode(input logic [31:0] a);
    logic [1:0] r;
    r = RESP_SLVERR;
    if (a[31:12] != SYS_PAGE || a[1:0] != 2'h0) begin
      r = RESP_DECERR;
    end else begin
      case (a[11:0])
        REG_RST_CTRL, REG_RST_STATUS, REG_RST_MODE,
        REG_NV_CMD, REG_NV_STATUS, REG_LOCK: r = RESP_OKAY;
        default: r = RESP_SLVERR;
      endcase
    end
    return r;
  endfunction : decode

  function automatic logic [31:0] read_word(input logic [31:0] a, input core_type s,
                                            input logic [PIN_COUNT-1:0] l,
                                            input logic uv);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (decode(a) == RESP_OKAY) begin
      case (a[11:0])
        REG_RST_STATUS: begin
          d[CAUSE_LSB +: 3] = s.cause;
          d[UV_BIT] = uv;
          d[LINE_BIT] = l[PIN_LINE];
        end
        REG_RST_MODE: d[PLEN_LSB +: 4] = s.plen;
        REG_NV_STATUS: begin
          d[NV_COUNT-1:0] = s.nv;
          d[CALIB_LSB +: CALIB_W] = s.calib;
          d[CMDERR_BIT] = s.cmd_err;
          d[FAST_BIT] = s.fast;
          d[RECOVER_BIT] = s.recover;
          d[ERASE_BIT] = l[PIN_ERASE];
        end
        REG_LOCK: d[LOCK_COUNT-1:0] = s.lock;
        default: d = 32'h0000_0000;
      endcase
    end
    return d;
  endfunction : read_word

  // a write executes in the first cycle that both its address and data are held
  assign bus_wr = st.aw_held && st.w_held && !st.bvalid;
  assign bus_cmd = bus_wr && decode(st.awaddr) == RESP_OKAY
                   && st.awaddr[11:0] == REG_NV_CMD;
  assign fpp_cmd_ready = st.fast && !bus_cmd;

  always_comb begin
    cmd_go = 1'b0;
    cmd_v = 8'h00;
    arg_v = 8'h00;
    if (bus_cmd && st.wstrb == 4'hF && st.wdata[KEY_LSB +: 8] == WR_KEY) begin
      cmd_go = 1'b1;
      cmd_v = st.wdata[7:0];
      arg_v = st.wdata[ARG_LSB +: 8];
    end else if (fpp_cmd_valid && fpp_cmd_ready) begin
      cmd_go = 1'b1;
      cmd_v = fpp_cmd_word[7:0];
      arg_v = fpp_cmd_word[15:8];
    end
  end

  always_comb begin
    next_st = st;
    // bus channels
    if (axi_req.awvalid && axi_rsp.awready) begin
      next_st.aw_held = 1'b1;
      next_st.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      next_st.w_held = 1'b1;
      next_st.wdata = axi_req.wdata;
      next_st.wstrb = axi_req.wstrb;
    end
    if (st.bvalid && axi_req.bready) begin
      next_st.bvalid = 1'b0;
    end
    if (bus_wr) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = decode(st.awaddr);
      if (next_st.bresp == RESP_OKAY && st.awaddr[11:0] == REG_RST_MODE
          && st.wstrb[1]) begin
        next_st.plen = st.wdata[PLEN_LSB +: 4];
      end
      if (next_st.bresp == RESP_OKAY && st.awaddr[11:0] == REG_RST_CTRL
          && st.wstrb == 4'hF && st.wdata[KEY_LSB +: 8] == WR_KEY
          && st.wdata[SWRST_BIT]) begin
        next_st.swrst = 1'b1;
      end
    end
    if (st.rvalid && axi_req.rready) begin
      next_st.rvalid = 1'b0;
    end
    if (axi_req.arvalid && axi_rsp.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = decode(axi_req.araddr);
      next_st.rdata = read_word(axi_req.araddr, st, lv, uv_detect);
    end
    // nonvolatile commands; calibration bits have no command path
    if (cmd_go) begin
      next_st.cmd_err = 1'b0;
      case (cmd_v)
        CMD_SET_NV, CMD_CLR_NV: begin
          if (arg_v < 8'(NV_COUNT)) begin
            next_st.nv[arg_v[0]] = (cmd_v == CMD_SET_NV);
          end else begin
            next_st.cmd_err = 1'b1;
          end
        end
        CMD_SET_LOCK, CMD_CLR_LOCK: begin
          if (arg_v < 8'(LOCK_COUNT)) begin
            next_st.lock[arg_v[3:0]] = (cmd_v == CMD_SET_LOCK);
          end else begin
            next_st.cmd_err = 1'b1;
          end
        end
        default: next_st.cmd_err = 1'b1;
      endcase
    end
    // erase wins over any command in the same cycle
    if (erase_level) begin
      next_st.nv[0] = 1'b0;
      next_st.nv[1] = 1'b0;
      next_st.lock = '0;
    end
    // mode pins are read once, after the synchronisers have settled
    if (!st.sampled) begin
      if (st.settle == SYNC_SETTLE) begin
        next_st.sampled = 1'b1;
        next_st.fast = lv[PIN_TEST] && lv[PIN_MS0] && lv[PIN_MS1]
                       && !lv[PIN_MS2];
        next_st.recover = lv[PIN_TEST] && lv[PIN_MS0] && lv[PIN_MS1]
                          && lv[PIN_MS2];
      end else begin
        next_st.settle = st.settle + 3'h1;
      end
    end
    // reset sequencer; the line is only seen as a user reset when idle
    case (st.seq)
      SEQ_IDLE: begin
        if (uv_req || watchdog_reset || st.swrst || !line_level) begin
          next_st.seq = SEQ_PULSE;
          next_st.count = 11'h000;
          next_st.swrst = next_st.swrst && !st.swrst; // a write landing now stays pending unless a swrst was already pending
          if (uv_req) begin
            next_st.cause = CAUSE_UV;
          end else if (watchdog_reset) begin
            next_st.cause = CAUSE_WATCHDOG;
          end else if (st.swrst) begin
            next_st.cause = CAUSE_SOFTWARE;
          end else begin
            next_st.cause = CAUSE_USER;
          end
        end
      end
      SEQ_PULSE: begin
        if (st.count == target - 11'h001) begin
          next_st.seq = SEQ_WAIT;
        end else begin
          next_st.count = st.count + 11'h001;
        end
      end
      SEQ_WAIT: begin
        // hold until the line floats high and the supply has recovered
        if (line_level && !uv_req) begin
          next_st.seq = SEQ_IDLE;
        end
      end
      default: next_st.seq = SEQ_IDLE;
    endcase
    next_st.oe = (next_st.seq == SEQ_PULSE);
    next_st.core_rst = (next_st.seq != SEQ_IDLE);
    next_st.inhibit = uv_detect;
    // power-on: everything restarts, nv bits reload from the array
    if (sys_rst) begin
      next_st = '0;
      next_st.nv = nv_stored;
      next_st.calib = calib_stored;
      next_st.plen = PLEN_RESET;
      next_st.cause = CAUSE_POWER;
      next_st.seq = SEQ_PULSE;
      next_st.oe = 1'b1;
      next_st.core_rst = 1'b1;
      next_st.inhibit = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    st <= next_st;
  end

  assign axi_rsp = '{awready: !st.aw_held && !st.bvalid, wready: !st.w_held && !st.bvalid,
                     bresp: st.bresp, bvalid: st.bvalid, arready: !st.rvalid,
                     rdata: st.rdata, rresp: st.rresp, rvalid: st.rvalid};

  // open drain: only ever pulls low
  assign external_reset_line_out = 1'b0;
  assign external_reset_line_oe = st.oe;
  assign undervoltage_detector_enable = st.nv[0];
  assign nv_image = st.nv;
  assign calib_bits = st.calib;
  assign lock_bits = st.lock;
  assign flash_inhibit = st.inhibit;
  assign core_reset = st.core_rst;
  assign fast_programming_port_enable = st.fast;
  assign boot_recovery = st.recover;

  a_erase_nv: assert property (
    @(posedge mclk) disable iff (sys_rst)
    erase_level |=> st.nv == '0)
    else $error("erase left an nv bit set");
  a_erase_lock: assert property (
    @(posedge mclk) disable iff (sys_rst)
    erase_level |=> st.lock == '0)
    else $error("erase left a lock bit set");
  a_calib_fixed: assert property (
    @(posedge mclk) disable iff (sys_rst)
    !$past(sys_rst) |-> $stable(st.calib))
    else $error("calibration bits changed");
  a_nv_set: assert property (
    @(posedge mclk) disable iff (sys_rst)
    cmd_go && cmd_v == CMD_SET_NV && arg_v == 8'h01 && !erase_level |=> st.nv[1])
    else $error("set command did not set nv bit 1");
  a_uv_reset: assert property (
    @(posedge mclk) disable iff (sys_rst)
    st.seq == SEQ_IDLE && uv_req |=> st.cause == CAUSE_UV && st.oe && st.core_rst)
    else $error("undervoltage reset not started");
  a_pulse_end: assert property (
    @(posedge mclk) disable iff (sys_rst)
    st.seq == SEQ_PULSE && st.count == target - 11'h001 |=> !st.oe ##1 !st.oe)
    else $error("reset pulse length wrong");
  a_cause_hold: assert property (
    @(posedge mclk) disable iff (sys_rst)
    st.seq != SEQ_IDLE |=> $stable(st.cause))
    else $error("reset cause changed during reset");
  a_por_cause: assert property (
    @(posedge mclk)
    $fell(sys_rst) |-> st.cause == CAUSE_POWER && st.core_rst && st.inhibit)
    else $error("power-on reset not reported");
  a_boot_once: assert property (
    @(posedge mclk) disable iff (sys_rst)
    st.sampled |=> $stable({st.fast, st.recover}))
    else $error("boot mode changed after sampling");
  a_fast_mode: assert property (
    @(posedge mclk) disable iff (sys_rst)
    $rose(st.sampled) |-> st.fast == $past(lv[PIN_TEST] && lv[PIN_MS0]
                                           && lv[PIN_MS1] && !lv[PIN_MS2]))
    else $error("fast programming decode wrong");
  a_inhibit: assert property (
    @(posedge mclk) disable iff (sys_rst)
    uv_detect |=> st.inhibit)
    else $error("flash not inhibited on undervoltage");
endmodule : nv_reset_boot_config
`default_nettype wire

/* sim/board_model.sv */
// board_model: board side of the reset line and the erase pin.
// assumes line_oe high means the block pulls the open-drain line low.
`timescale 1ns/10ps
`default_nettype none
module board_model (
  // block side
  input wire logic line_oe,
  output logic line_level,
  output logic erase_level,
  // bench controls
  input wire logic button,
  input wire logic erase_drive
);
  // open drain with pull-up: whoever pulls low wins
  assign line_level = !(line_oe || button);
  // a released erase pin sits at its pull-down level
  assign erase_level = erase_drive ? 1'b1 : 1'b0;
endmodule : board_model
`default_nettype wire

/* sim/nv_reset_boot_config_tb.sv */
// nv_reset_boot_config_tb: self-checking bench of the reset and boot block.
// assumes board_model for the line and erase pin; nv store kept across power-on resets.
`timescale 1ns/10ps
`default_nettype none
module nv_reset_boot_config_tb import reset_boot_pkg::*;;
  logic mclk = 0, sys_rst = 1, tst, m0, m1, m2, line_in, oe, uv_raw, wdog, fpp_v;
  logic button, erase_drive, erase, fast, rec, fpp_rdy, uv_en, finh, core, lo;
  logic [15:0] fpp_w, locks;
  logic [1:0] nv;
  logic [1:0] nv_keep = 2'h2;
  logic [7:0] calo;
  logic [31:0] d;
  axi_req_type rq;
  axi_rsp_type rs;
  int n_mismatch = 0, compares = 0;
  always #4 mclk = ~mclk;
  // nonvolatile store: follows the bits while running, reloads them at power-on
  always @(posedge mclk) begin
    if (!sys_rst) nv_keep <= nv;
  end
  nv_reset_boot_config nv_reset_boot_config_i (.mclk(mclk), .sys_rst(sys_rst),
    .axi_req(rq), .axi_rsp(rs), .erase_pin(erase), .test_mode_pin(tst),
    .mode_select_line_0(m0), .mode_select_line_1(m1), .mode_select_line_2(m2),
    .external_reset_line_in(line_in), .external_reset_line_out(lo),
    .external_reset_line_oe(oe), .undervoltage_detector_raw(uv_raw), .nv_stored(nv_keep),
    .calib_stored(8'h5A), .undervoltage_detector_enable(uv_en), .nv_image(nv),
    .calib_bits(calo), .lock_bits(locks), .flash_inhibit(finh), .watchdog_reset(wdog),
    .core_reset(core), .fast_programming_port_enable(fast), .boot_recovery(rec),
    .fpp_cmd_valid(fpp_v), .fpp_cmd_word(fpp_w), .fpp_cmd_ready(fpp_rdy));
  board_model board_model_i (.line_oe(oe), .line_level(line_in), .erase_level(erase),
    .button(button), .erase_drive(erase_drive));
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic tmo;
    n_mismatch++;
    $display("wait limit reached at %0t", $time);
    conclude();
  endtask : tmo
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [31:0] ad(input logic [11:0] o);
    return {SYS_PAGE, o};
  endfunction : ad
  // write: both channels offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk);
    rq.awaddr <= a; rq.awvalid <= 1; rq.wdata <= v; rq.wstrb <= 4'hF;
    rq.wvalid <= 1; rq.bready <= 1;
    while (n < 200) begin
      @(posedge mclk);
      n++;
      if (rq.awvalid && rs.awready) rq.awvalid <= 0;
      if (rq.wvalid && rs.wready) rq.wvalid <= 0;
      if (rs.bvalid) break;
    end
    if (n >= 200) tmo();
    chk(32'(rs.bresp), 32'(er));
    rq.bready <= 0;
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk);
    rq.araddr <= a; rq.arvalid <= 1; rq.rready <= 1;
    while (n < 200) begin
      @(posedge mclk);
      n++;
      if (rq.arvalid && rs.arready) rq.arvalid <= 0;
      if (rs.rvalid) break;
    end
    if (n >= 200) tmo();
    chk(32'(rs.rresp), 32'(er));
    d = rs.rdata;
    rq.rready <= 0;
  endtask : rd
  task automatic nvcmd(input logic [7:0] c, input logic [7:0] a);
    wr(ad(REG_NV_CMD), {WR_KEY, 8'h00, a, c}, RESP_OKAY);
  endtask : nvcmd
  task automatic wait_core(input logic lvl);
    int n;
    n = 0;
    while (core !== lvl && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 3000) tmo();
  endtask : wait_core
  task automatic cause_is(input logic [2:0] exp);
    wait_core(0);
    rd(ad(REG_RST_STATUS), RESP_OKAY);
    chk(32'(d[CAUSE_LSB+:3]), 32'(exp));
  endtask : cause_is
  // counts the cycles for which the line is pulled low
  task automatic measure(input int exp);
    int n;
    n = 0;
    while (oe !== 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    n = 0;
    while (oe === 1'b1 && n < 1000) begin
      @(posedge mclk);
      n++;
    end
    chk(32'(n), 32'(exp));
  endtask : measure
  task automatic t_boot(input logic [3:0] p, input logic ef, input logic er,
                        input logic [1:0] en);
    {tst, m0, m1, m2} <= p;
    sys_rst <= 1;
    repeat (16) @(posedge mclk);
    chk(32'(finh), 32'h1);
    sys_rst <= 0;
    cause_is(CAUSE_POWER);
    chk(32'(fast), 32'(ef));
    chk(32'(rec), 32'(er));
    chk(32'(nv), 32'(en));
    chk(32'(calo), 32'h5A);
    // pins moving after the sample point must not change the mode
    m2 <= !p[0];
    tst <= 0;
    repeat (10) @(posedge mclk);
    chk(32'(fast), 32'(ef));
    $display("boot mode test done");
  endtask : t_boot
  task automatic t_nv;
    nvcmd(CMD_SET_NV, 8'h00);
    chk(32'(nv), 32'h3);
    chk(32'(uv_en), 32'h1);
    nvcmd(CMD_CLR_NV, 8'h01);
    chk(32'(nv), 32'h1);
    nvcmd(CMD_SET_LOCK, 8'h03);
    chk(32'(locks), 32'h8);
    nvcmd(CMD_CLR_LOCK, 8'h03);
    chk(32'(locks), 32'h0);
    nvcmd(8'h77, 8'h00);
    rd(ad(REG_NV_STATUS), RESP_OKAY);
    chk(32'({d[CMDERR_BIT], 7'h0, d[15:0]}), 32'({1'b1, 7'h0, 8'h5A, 8'h01}));
    $display("nv command test done");
  endtask : t_nv
  task automatic t_uv;
    uv_raw <= 1;
    repeat (200) @(posedge mclk);
    chk(32'(core), 32'h0);
    chk(32'(finh), 32'h1);
    rd(ad(REG_RST_STATUS), RESP_OKAY);
    chk(32'(d[UV_BIT]), 32'h1);
    uv_raw <= 0;
    // let the qualified detect drop before the reset enable lands
    repeat (8) @(posedge mclk);
    nvcmd(CMD_SET_NV, 8'h01);
    uv_raw <= 1;
    repeat (40) @(posedge mclk);
    uv_raw <= 0;
    repeat (20) @(posedge mclk);
    chk(32'(core), 32'h0);
    uv_raw <= 1;
    wait_core(1);
    uv_raw <= 0;
    cause_is(CAUSE_UV);
    $display("undervoltage test done");
  endtask : t_uv
  task automatic t_sources;
    wdog <= 1;
    @(posedge mclk);
    wdog <= 0;
    measure((PLEN_RESET + 1) * PULSE_UNIT_CYCLES);
    chk(32'(lo), 32'h0);
    cause_is(CAUSE_WATCHDOG);
    wr(ad(REG_RST_MODE), 32'h0, RESP_OKAY);
    wr(ad(REG_RST_CTRL), {WR_KEY, 24'h1}, RESP_OKAY);
    measure(PULSE_UNIT_CYCLES);
    cause_is(CAUSE_SOFTWARE);
    wr(ad(REG_RST_MODE), 32'h100, RESP_OKAY);
    button <= 1;
    repeat (12) @(posedge mclk);
    button <= 0;
    cause_is(CAUSE_USER);
    wr(ad(12'hD0C), 32'h0, RESP_SLVERR);
    rd(32'h0000_0D04, RESP_DECERR);
    $display("reset source test done");
  endtask : t_sources
  task automatic t_erase;
    nvcmd(CMD_SET_NV, 8'h00);
    nvcmd(CMD_SET_LOCK, 8'h05);
    // held far shorter than the board must, to keep the run short
    erase_drive <= 1;
    repeat (64) @(posedge mclk);
    erase_drive <= 0;
    repeat (8) @(posedge mclk);
    chk(32'(nv), 32'h0);
    chk(32'(locks), 32'h0);
    chk(32'(calo), 32'h5A);
    $display("erase test done");
  endtask : t_erase
  task automatic t_fpp;
    int n;
    n = 0;
    fpp_w <= {8'h01, CMD_SET_NV};
    fpp_v <= 1;
    while (n < 50) begin
      @(posedge mclk);
      n++;
      if (fpp_rdy) break;
    end
    fpp_v <= 0;
    if (n >= 50) tmo();
    @(posedge mclk);
    chk(32'(nv), 32'h2);
    $display("fast port test done");
  endtask : t_fpp
  initial begin
    rq = '0;
    {tst, m0, m1, m2, uv_raw, wdog, fpp_v, button, erase_drive} = '0;
    fpp_w = 16'h0000;
    t_boot(4'h0, 0, 0, 2'h2);
    t_nv();
    t_uv();
    t_sources();
    t_erase();
    t_boot(4'hF, 0, 1, 2'h0);
    t_boot(4'hC, 0, 0, 2'h0);
    t_boot(4'hE, 1, 0, 2'h0);
    t_fpp();
    conclude();
  end
endmodule : nv_reset_boot_config_tb
`default_nettype wire
